//--- logic/cers_pkg.sv
/*
  Package of constants for the exception and reset sequencer.
  Assumes a 32-bit byte-addressed memory bus with word-aligned vector fetches.
*/
`default_nettype none
package cers_pkg;
  localparam logic [31:0] POR_PC_ADDR   = 32'h0000_0000;
  localparam logic [31:0] POR_SP_ADDR   = 32'h0000_0004;
  localparam logic [31:0] MRST_PC_ADDR  = 32'h0000_0008;
  localparam logic [31:0] MRST_SP_ADDR  = 32'h0000_000C;
  localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
  localparam logic [3:0]  MASK_RESET    = 4'hF;
  localparam logic [3:0]  NMI_MASK      = 4'hF;
  localparam logic [4:0]  NMI_LEVEL     = 5'h10;
  localparam int          MASK_LSB      = 4;
  localparam logic [7:0]  VEC_GEN_ILL   = 8'h04;
  localparam logic [7:0]  VEC_SLOT_ILL  = 8'h06;
  localparam logic [7:0]  VEC_ADDR_ERR  = 8'h09;
  localparam logic [31:0] STACK_STEP    = 32'h0000_0004;
  localparam logic [31:0] SR_RESET      = 32'h0000_00F0;
  typedef enum logic [1:0] {CERS_SRC_ADDR, CERS_SRC_INT, CERS_SRC_INSN} cers_src_t;
endpackage
`default_nettype wire

//--- logic/cers_pin_sync.sv
/*
  Two-stage synchroniser with rising-edge detect for an external reset pin.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cers_pin_sync #(
  // Level that all stages show while the block is held in reset.
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin and results.
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  // Synchronise and remember the previous level; reset loads RESET_LEVEL into every stage, so no false edge follows if the pin rests at that level.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
      prev_q <= RESET_LEVEL;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
endmodule // cers_pin_sync
`default_nettype wire

//--- logic/cers_sequencer.sv
/*
  Exception and reset sequencer of a 32-bit core: ranks sources, runs
  reset vector fetch and exception stacking, and forms vector addresses.
  Assumes a simple one-word memory port answering with memAck, and a
  decoder that reports instruction boundaries and decode classifications.
*/
`timescale 1ns/1ps
`default_nettype none
module cers_sequencer
  import cers_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // External reset pins and watchdog.
  input  wire logic        powerOnResetPin,
  input  wire logic        manualResetPin,
  input  wire logic        wdtOverflowReset,
  // Decoder status.
  input  wire logic        insnBoundary,
  input  wire logic        inDelaySlot,
  input  wire logic        decUndefined,
  input  wire logic        decPcWriter,
  input  wire logic        trapExec,
  input  wire logic [7:0]  trapVector,
  // Address error and interrupt requests.
  input  wire logic        addrErrReq,
  input  wire logic        intReq,
  input  wire logic [4:0]  intLevel,
  input  wire logic [7:0]  intVector,
  // Core register values.
  input  wire logic [31:0] curSr,
  input  wire logic [31:0] curPc,
  input  wire logic [31:0] curSp,
  input  wire logic        busCycleActive,
  // Memory port.
  output logic             memReq,
  output logic             memWrite,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  input  wire logic [31:0] memRdata,
  input  wire logic        memAck,
  // Core register updates.
  output logic [31:0]      newPc,
  output logic [31:0]      newSp,
  output logic [31:0]      vectorBase,
  output logic [3:0]       intMask,
  output logic             loadPc,
  output logic             coreHold,
  output logic             intAck,
  // Reset outputs.
  output logic             cpuResetActive,
  output logic             periphReset,
  output logic             pinFuncReset,
  output logic             clearWdtOverflow
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_POR_HOLD, ST_MRST_WAIT, ST_MRST_HOLD, ST_RST_PC, ST_RST_SP,
    ST_PUSH_SR, ST_PUSH_PC, ST_FETCH_VEC, ST_RUN
  } cers_state_t;

  logic        porLevel, mrLevel, mrRise;
  cers_state_t state_q;
  logic        manualSeq_q;
  logic [31:0] pcFetch_q;
  logic [31:0] sp_q;
  logic [31:0] srSave_q;
  logic [31:0] pcSave_q;
  logic [7:0]  vector_q;
  cers_src_t   src_q;
  logic [4:0]  level_q;
  logic        addrPend_q;
  logic        canAccept;
  logic        insnExc;
  logic [7:0]  insnVec;
  // Assertions below share this clock and are off while reset is held.
  default clocking cbMain @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Power-on and manual pins are synchronised before use.
  cers_pin_sync #(.RESET_LEVEL(1'b0)) u_porSync (
    .clk   (clk),
    .rst_b (rst_b),
    .pinIn (powerOnResetPin),
    .level (porLevel),
    .rise  ()
  );
  cers_pin_sync u_mrSync (
    .clk   (clk),
    .rst_b (rst_b),
    .pinIn (manualResetPin),
    .level (mrLevel),
    .rise  (mrRise)
  );

  // Vector table address: base plus vector number times four.
  function automatic logic [31:0] vecAddr(input logic [31:0] base, input logic [7:0] num);
    vecAddr = base + {22'h0, num, 2'h0};
  endfunction

  // Address errors and interrupts are taken only at a boundary outside a slot.
  assign canAccept = insnBoundary & ~inDelaySlot;
  // Instruction-triggered exception classification.
  assign insnExc = trapExec | decUndefined | (inDelaySlot & decPcWriter);
  assign insnVec = (inDelaySlot & (decUndefined | decPcWriter)) ? VEC_SLOT_ILL :
                   decUndefined ? VEC_GEN_ILL :
                   trapVector;

  // Pending latch for address errors; interrupts stay pending in their controller, which holds the level.
  // A request meeting an accepting boundary is served by that entry, so it is not latched a second time.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrPend_q <= 1'b0;
    end else if (state_q == ST_POR_HOLD || state_q == ST_MRST_HOLD) begin
      addrPend_q <= 1'b0;
    end else if (state_q == ST_RUN && mrLevel && canAccept) begin
      addrPend_q <= 1'b0;
    end else if (addrErrReq) begin
      addrPend_q <= 1'b1;
    end
  end

  // Main sequencer state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_POR_HOLD;
      manualSeq_q <= 1'b0;
      src_q       <= CERS_SRC_INSN;
      vector_q    <= 8'h00;
      level_q     <= 5'h00;
    end else if (!porLevel || wdtOverflowReset) begin
      state_q     <= ST_POR_HOLD;
      manualSeq_q <= 1'b0;
    end else begin
      case (state_q)
        ST_POR_HOLD: begin
          state_q <= ST_RST_PC;
        end
        ST_MRST_WAIT: begin
          if (!busCycleActive) begin
            state_q <= ST_MRST_HOLD;
          end
        end
        ST_MRST_HOLD: begin
          if (mrRise) begin
            state_q     <= ST_RST_PC;
            manualSeq_q <= 1'b1;
          end
        end
        ST_RST_PC: begin
          if (memAck) begin
            state_q <= ST_RST_SP;
          end
        end
        ST_RST_SP: begin
          if (memAck) begin
            state_q <= ST_RUN;
          end
        end
        ST_PUSH_SR: begin
          if (memAck) begin
            state_q <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: begin
          if (memAck) begin
            state_q <= ST_FETCH_VEC;
          end
        end
        ST_FETCH_VEC: begin
          if (memAck) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN, ST_IDLE: begin
          if (!mrLevel) begin
            state_q <= ST_MRST_WAIT;
          end else if ((addrErrReq || addrPend_q) && canAccept) begin
            state_q  <= ST_PUSH_SR;
            src_q    <= CERS_SRC_ADDR;
            vector_q <= VEC_ADDR_ERR;
          end else if (intReq && canAccept) begin
            state_q  <= ST_PUSH_SR;
            src_q    <= CERS_SRC_INT;
            vector_q <= intVector;
            level_q  <= intLevel;
          end else if (insnExc && insnBoundary) begin
            state_q  <= ST_PUSH_SR;
            src_q    <= CERS_SRC_INSN;
            vector_q <= insnVec;
          end
        end
        default: begin
          state_q <= ST_POR_HOLD;
        end
      endcase
    end
  end

  // Snapshot of status word and PC when an exception is taken; the stack pointer is copied in the memory request block.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srSave_q <= SR_RESET;
      pcSave_q <= 32'h0000_0000;
    end else if ((state_q == ST_RUN || state_q == ST_IDLE) && porLevel && mrLevel) begin
      srSave_q <= curSr;
      pcSave_q <= curPc;
    end
  end

  // Memory request: address, data and direction per state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= 32'h0000_0000;
      memWdata <= 32'h0000_0000;
      sp_q     <= 32'h0000_0000;
    end else begin
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      case (state_q)
        ST_RST_PC: begin
          memReq  <= ~memAck;
          memAddr <= manualSeq_q ? MRST_PC_ADDR : POR_PC_ADDR;
        end
        ST_RST_SP: begin
          memReq  <= ~memAck;
          memAddr <= manualSeq_q ? MRST_SP_ADDR : POR_SP_ADDR;
        end
        ST_PUSH_SR: begin
          memReq   <= ~memAck;
          memWrite <= ~memAck;
          memAddr  <= sp_q - STACK_STEP;
          memWdata <= srSave_q;
          if (memAck) begin
            sp_q <= sp_q - STACK_STEP;
          end
        end
        ST_PUSH_PC: begin
          memReq   <= ~memAck;
          memWrite <= ~memAck;
          memAddr  <= sp_q - STACK_STEP;
          memWdata <= pcSave_q;
          if (memAck) begin
            sp_q <= sp_q - STACK_STEP;
          end
        end
        ST_FETCH_VEC: begin
          memReq  <= ~memAck;
          memAddr <= vecAddr(vectorBase, vector_q);
        end
        default: begin
          sp_q <= curSp;
        end
      endcase
    end
  end

  // Core register updates: PC, SP, vector base and mask field.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pcFetch_q  <= 32'h0000_0000;
      newPc      <= 32'h0000_0000;
      newSp      <= 32'h0000_0000;
      vectorBase <= VBR_RESET;
      intMask    <= MASK_RESET;
      loadPc     <= 1'b0;
      intAck     <= 1'b0;
    end else begin
      loadPc <= 1'b0;
      intAck <= 1'b0;
      if (state_q == ST_POR_HOLD || state_q == ST_MRST_HOLD) begin
        vectorBase <= VBR_RESET;
        intMask    <= MASK_RESET;
      end
      if (state_q == ST_RST_PC && memAck) begin
        pcFetch_q <= memRdata;
      end
      if (state_q == ST_RST_SP && memAck) begin
        newPc  <= pcFetch_q;
        newSp  <= memRdata;
        loadPc <= 1'b1;
      end
      if (state_q == ST_PUSH_PC && memAck) begin
        newSp <= sp_q - STACK_STEP;
        if (src_q == CERS_SRC_INT) begin
          intMask <= (level_q == NMI_LEVEL) ? NMI_MASK : level_q[3:0];
          intAck  <= 1'b1;
        end
      end
      if (state_q == ST_FETCH_VEC && memAck) begin
        newPc  <= memRdata;
        loadPc <= 1'b1;
      end
    end
  end

  // Reset outputs: peripherals on power-on and watchdog, pin functions only on the power-on pin.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuResetActive   <= 1'b1;
      periphReset      <= 1'b1;
      pinFuncReset     <= 1'b1;
      clearWdtOverflow <= 1'b0;
    end else begin
      cpuResetActive   <= (state_q == ST_POR_HOLD) || (state_q == ST_MRST_HOLD);
      periphReset      <= !porLevel || wdtOverflowReset;
      pinFuncReset     <= !porLevel;
      clearWdtOverflow <= !porLevel && wdtOverflowReset;
    end
  end

  assign coreHold = (state_q != ST_RUN) && (state_q != ST_IDLE);

  // Assertions.
  property p_rstVec;
      (memReq && state_q == ST_RST_PC) |-> (memAddr == POR_PC_ADDR || memAddr == MRST_PC_ADDR);
  endproperty
  a_rstVec: assert property (p_rstVec) else $error("Bad reset PC vector.");
  property p_mask;
      (state_q == ST_POR_HOLD) |=> (intMask == MASK_RESET && vectorBase == VBR_RESET);
  endproperty
  a_mask: assert property (p_mask) else $error("Reset did not init mask.");
  property p_nmi;
      intAck && level_q == NMI_LEVEL |-> intMask == NMI_MASK;
  endproperty
  a_nmi: assert property (p_nmi) else $error("NMI mask wrong.");
  property p_wdt;
      (porLevel && wdtOverflowReset) |=> !pinFuncReset && periphReset;
  endproperty
  a_wdt: assert property (p_wdt) else $error("Watchdog reset touched pin functions.");
  sequence s_pushSr;
    state_q == ST_PUSH_SR && memAck;
  endsequence
  property p_order;
      s_pushSr and porLevel and mrLevel and !wdtOverflowReset |=> state_q == ST_PUSH_PC;
  endproperty
  a_order: assert property (p_order) else $error("Stack order broken.");
  property p_mrstWait;
      (state_q == ST_MRST_WAIT && busCycleActive && porLevel && !wdtOverflowReset) |=> state_q == ST_MRST_WAIT;
  endproperty
  a_mrstWait: assert property (p_mrstWait) else $error("Manual reset entered during a bus cycle.");
endmodule // cers_sequencer
`default_nettype wire

//--- bench/cers_mem_model.sv
/*
  Memory partner of the sequencer: answers each word access after a wait.
  Assumes the requester holds a request until memAck.
*/
`timescale 1ns/1ps
`default_nettype none
module cers_mem_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Memory port.
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [1:0]  waitCycles,
  output logic [31:0]      memRdata,
  output logic             memAck
);
  logic [1:0] cnt;

  // Counts wait cycles and then acks once; read data is valid only with memAck.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 2'h0;
      memAck   <= 1'h0;
      memRdata <= 32'h0;
    end else if (memAck || !memReq) begin
      cnt      <= 2'h0;
      memAck   <= 1'h0;
      memRdata <= ~memRdata; // Stale data is never held.
    end else if (cnt >= waitCycles) begin
      memAck   <= 1'h1;
      memRdata <= memWrite ? ~memRdata : (32'h5A00_0000 ^ memAddr);
    end else begin
      cnt      <= cnt + 2'h1;
      memRdata <= ~memRdata;
    end
  end
endmodule // cers_mem_model
`default_nettype wire

//--- bench/cers_sequencer_tb_top.sv
/*
  Self-checking bench of the exception and reset sequencer.
  Assumes the memory partner returns 5A000000 xor address on reads.
*/
`timescale 1ns/1ps
`default_nettype none
module cers_sequencer_tb_top;
  import cers_pkg::*;
  logic        clk, rst_b, powerOnResetPin, manualResetPin, wdtOverflowReset, insnBoundary;
  logic        inDelaySlot, decUndefined, decPcWriter, trapExec, addrErrReq, intReq, busCycleActive;
  logic        memReq, memWrite, memAck, loadPc, coreHold, intAck, cpuResetActive;
  logic        periphReset, pinFuncReset, clearWdtOverflow, pf, pr, ia;
  logic [7:0]  trapVector, intVector, v;
  logic [4:0]  intLevel;
  logic [3:0]  intMask, mk;
  logic [1:0]  waitCycles;
  logic [31:0] curSr, curPc, curSp, memAddr, memWdata, memRdata, newPc, newSp, vectorBase;
  logic [64:0] blog[$];
  integer      errors, cmp_count, seed, i;

  cers_sequencer i_dut (.clk, .rst_b, .powerOnResetPin, .manualResetPin, .wdtOverflowReset,
    .insnBoundary, .inDelaySlot, .decUndefined, .decPcWriter, .trapExec, .trapVector, .addrErrReq,
    .intReq, .intLevel, .intVector, .curSr, .curPc, .curSp, .busCycleActive, .memReq, .memWrite,
    .memAddr, .memWdata, .memRdata, .memAck, .newPc, .newSp, .vectorBase, .intMask, .loadPc,
    .coreHold, .intAck, .cpuResetActive, .periphReset, .pinFuncReset, .clearWdtOverflow);
  cers_mem_model i_mem (.clk, .rst_b, .memReq, .memWrite, .memAddr, .waitCycles, .memRdata, .memAck);

  // The clock toggles every half period of 20 ns.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Every completed bus access is logged as direction, address and data.
  always @(posedge clk) begin
    if (memReq === 1'h1 && memAck === 1'h1) blog.push_back({memWrite, memAddr, memWdata});
  end

  task step;
    @(posedge clk);
    #1;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Waits for the load pulse, noting reset outputs and ending the request on acceptance.
  task wait_load(input string n);
    int k;
    k = 0;
    pf = 1'h0;
    pr = 1'h0;
    ia = 1'h0;
    while (k < 300 && loadPc !== 1'h1) begin
      step;
      pf |= pinFuncReset;
      pr |= periphReset;
      ia |= intAck;
      if (intAck === 1'h1) intReq = 1'h0;
      k++;
    end
    chk({n, " load"}, 32'h1, {31'h0, loadPc});
  endtask

  task bus(input int k, input logic w, input logic [31:0] a);
    chk("bus dir", {31'h0, w}, {31'h0, blog[k][64]});
    chk("bus addr", a, blog[k][63:32]);
  endtask

  // A reset sequence reads PC then SP from a and a+4 and reinitialises base and mask.
  task rchk(input string n, input logic [31:0] a);
    wait_load(n);
    chk("reset reads", 32'h2, blog.size());
    bus(0, 1'h0, a);
    bus(1, 1'h0, a + 32'h4);
    chk("newPc", 32'h5A00_0000 ^ a, newPc);
    chk("newSp", 32'h5A00_0000 ^ (a + 32'h4), newSp);
    chk("vector base", 32'h0, vectorBase);
    chk("mask", 32'hF, {28'h0, intMask});
    mk = 4'hF;
    $display("test %s done", n);
  endtask

  // One exception: f is slot, undefined, PC writer, trap, address error, interrupt.
  task exc(input string n, input logic [5:0] f, input logic [7:0] vn, input logic [3:0] em);
    blog.delete();
    curSp = $random(seed) & 32'hFFFF_FFFC;
    curSr = $random(seed);
    curPc = $random(seed);
    waitCycles = $random(seed);
    {inDelaySlot, decUndefined, decPcWriter, trapExec, addrErrReq, intReq} = f;
    trapVector = (f[1:0] == 2'h0) ? vn : ~vn;
    intVector = f[1] ? ~vn : vn;
    insnBoundary = 1'h1;
    step;
    {insnBoundary, inDelaySlot, decUndefined, decPcWriter, trapExec, addrErrReq} = 6'h0;
    wait_load(n);
    intReq = 1'h0;
    chk("stack accesses", 32'h3, blog.size());
    bus(0, 1'h1, curSp - 32'h4);
    chk("pushed status", curSr, blog[0][31:0]);
    bus(1, 1'h1, curSp - 32'h8);
    chk("pushed pc", curPc, blog[1][31:0]);
    bus(2, 1'h0, {22'h0, vn, 2'h0});
    chk("handler", 32'h5A00_0000 ^ {22'h0, vn, 2'h0}, newPc);
    chk("stack pointer", curSp - 32'h8, newSp);
    chk("mask", {28'h0, em}, {28'h0, intMask});
    chk("int ack", {31'h0, f == 6'h01}, {31'h0, ia});
    chk("core released", 32'h0, {31'h0, coreHold});
    mk = em;
    repeat (3) step;
    blog.delete();
    $display("test %s done", n);
  endtask

  // Main sequence: power-on, exceptions, watchdog and manual resets.
  initial begin
    seed = 16414;
    errors = 0;
    cmp_count = 0;
    {rst_b, powerOnResetPin, wdtOverflowReset, insnBoundary, inDelaySlot, decUndefined} = 6'h0;
    {decPcWriter, trapExec, addrErrReq, intReq, busCycleActive} = 5'h0;
    manualResetPin = 1'h1;
    {trapVector, intVector, intLevel, waitCycles, mk} = 27'h0;
    {curSr, curPc, curSp} = 96'h0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'h1;
    repeat (12) step;
    wdtOverflowReset = 1'h1;
    repeat (2) step;
    chk("overflow clear", 32'h1, {31'h0, clearWdtOverflow});
    chk("cpu reset", 32'h1, {31'h0, cpuResetActive});
    chk("periph reset", 32'h1, {31'h0, periphReset});
    chk("pin func reset", 32'h1, {31'h0, pinFuncReset});
    wdtOverflowReset = 1'h0;
    step;
    chk("held before rise", 32'h0, blog.size());
    powerOnResetPin = 1'h1;
    rchk("power on", 32'h0);
    for (i = 0; i < 3; i++) begin
      intLevel = 5'(($random(seed) & 32'hF) % 15 + 1);
      v = $random(seed);
      exc("interrupt", 6'h01, v, intLevel[3:0]);
      v = $random(seed);
      exc("trap", 6'h04, v, mk);
    end
    intLevel = 5'h10;
    exc("nmi", 6'h01, 8'h0B, 4'hF);
    exc("undefined", 6'h10, VEC_GEN_ILL, mk);
    exc("slot undefined", 6'h30, VEC_SLOT_ILL, mk);
    exc("slot pc writer", 6'h28, VEC_SLOT_ILL, mk);
    intLevel = 5'h3;
    {intReq, insnBoundary, inDelaySlot} = 3'h7;
    step;
    {insnBoundary, inDelaySlot} = 2'h0;
    repeat (6) step;
    chk("slot defers", 32'h0, blog.size());
    exc("after slot", 6'h01, 8'h40, 4'h3);
    addrErrReq = 1'h1;
    step;
    addrErrReq = 1'h0;
    repeat (6) step;
    chk("waits boundary", 32'h0, blog.size());
    exc("latched address error", 6'h00, VEC_ADDR_ERR, mk);
    intLevel = 5'h7;
    exc("priority", 6'h07, VEC_ADDR_ERR, mk);
    blog.delete();
    waitCycles = 2'h2;
    wdtOverflowReset = 1'h1;
    step;
    wdtOverflowReset = 1'h0;
    rchk("watchdog", 32'h0);
    chk("pin func kept", 32'h0, {31'h0, pf});
    blog.delete();
    busCycleActive = 1'h1;
    manualResetPin = 1'h0;
    repeat (6) step;
    chk("bus cycle kept", 32'h0, {31'h0, cpuResetActive});
    busCycleActive = 1'h0;
    repeat (20) step;
    chk("manual periph", 32'h0, {31'h0, periphReset});
    chk("manual reset state", 32'h1, {31'h0, cpuResetActive});
    chk("core held", 32'h1, {31'h0, coreHold});
    manualResetPin = 1'h1;
    rchk("manual", 32'h8);
    chk("manual periph run", 32'h0, {31'h0, pr});
    complete_run;
  end

  // A hang is cut short after far more cycles than the tests need.
  initial begin
    #800000;
    $display("watchdog expired");
    errors++;
    complete_run;
  end
endmodule // cers_sequencer_tb_top
`default_nettype wire
